// [design/vrir_pkg.sv]
// vrir_pkg: register map, field positions, reset values and codes shared by
// the VCONN status, soft reset, reserved and extended mask register bank.
// assumes a byte-wide register port driven by an I2C slave engine on clk.
package vrir_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] VRIR_OFS_VCONN   = 8'h0A;
    localparam logic [7:0] VRIR_OFS_RESET   = 8'h10;
    localparam logic [7:0] VRIR_OFS_RSVD_A  = 8'h11;
    localparam logic [7:0] VRIR_OFS_RSVD_B  = 8'h12;
    localparam logic [7:0] VRIR_OFS_RSVD_C  = 8'h13;
    localparam logic [7:0] VRIR_OFS_RSVD_D  = 8'h14;
    localparam logic [7:0] VRIR_OFS_RSVD_E  = 8'h15;
    localparam logic [7:0] VRIR_OFS_RSVD_F  = 8'h16;
    localparam logic [7:0] VRIR_OFS_RSVD_G  = 8'h17;
    localparam logic [7:0] VRIR_OFS_MASK    = 8'h18;
    localparam logic [7:0] VRIR_OFS_STATUS  = 8'h19;
    localparam logic [7:0] VRIR_OFS_UNLOCK  = 8'h43;

    // fixed contents of the reserved registers
    localparam logic [7:0] VRIR_RST_RSVD_A  = 8'h0C;
    localparam logic [7:0] VRIR_RST_RSVD_B  = 8'h00;
    localparam logic [7:0] VRIR_RST_RSVD_C  = 8'hA1;
    localparam logic [7:0] VRIR_RST_RSVD_D  = 8'h1F;
    localparam logic [7:0] VRIR_RST_RSVD_E  = 8'hC9;
    localparam logic [7:0] VRIR_RST_RSVD_F  = 8'h51;
    localparam logic [7:0] VRIR_RST_RSVD_G  = 8'h50;

    // reset values of writable state and the unlock key
    localparam logic [4:0] VRIR_RST_MASK    = 5'h1F;
    localparam logic [7:0] VRIR_RST_UNLOCK  = 8'h00;
    localparam logic [7:0] VRIR_UNLOCK_KEY  = 8'hE0;

    // field positions
    localparam int VRIR_SOFT_RESET_BIT = 0;
    localparam int VRIR_EVT_WIDTH      = 5;
    localparam int VRIR_EVT_COMP       = 4;
    localparam int VRIR_EVT_ROLE       = 3;
    localparam int VRIR_EVT_ORIENT     = 2;
    localparam int VRIR_EVT_DEBUG      = 1;
    localparam int VRIR_EVT_AUDIO      = 0;

    // vconn detection codes
    localparam logic [1:0] VRIR_VCONN_STANDBY = 2'h0;
    localparam logic [1:0] VRIR_VCONN_CC1     = 2'h1;
    localparam logic [1:0] VRIR_VCONN_CC2     = 2'h2;

    // port configuration codes
    typedef enum logic [1:0] {
        VRIR_PORT_UFP = 2'h0,
        VRIR_PORT_DFP = 2'h1,
        VRIR_PORT_DRP = 2'h2
    } vrir_port_e;

endpackage

// [design/vrir_evt_if.sv]
// vrir_evt_if: carries event pulses, the read-clear strobe and the sticky
// status between the register bank and its event status keeper.
// assumes both ends run on the same clk.
`timescale 1ns/1ps
`default_nettype none
interface vrir_evt_if;
    import vrir_pkg::*;
    logic [VRIR_EVT_WIDTH-1:0] evt;
    logic                      rd_clr;
    logic [2:0]                role_in;
    logic [VRIR_EVT_WIDTH-1:0] status;
    logic [2:0]                role_q;

    modport bank   (output evt, output rd_clr, output role_in, input status, input role_q);
    modport keeper (input evt, input rd_clr, input role_in, output status, output role_q);
endinterface
`default_nettype wire

// [design/vrir_event_status.sv]
// vrir_event_status: sticky extended event status, cleared when read, and
// the attachment role field latched on a role change.
// assumes event pulses and the read strobe are on clk and one cycle long.
`timescale 1ns/1ps
`default_nettype none
module vrir_event_status
    import vrir_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    vrir_evt_if.keeper ev
);
    import vrir_pkg::*;

    logic [VRIR_EVT_WIDTH-1:0] status_q;
    logic [VRIR_EVT_WIDTH-1:0] status_d;
    logic [2:0]                role_q;

    // a new event wins over a read-clear in the same cycle
    always_comb begin
        status_d = ev.rd_clr ? '0 : status_q;
        status_d = status_d | ev.evt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            role_q <= 3'h0;
        end else if (ev.evt[VRIR_EVT_ROLE]) begin
            role_q <= ev.role_in;
        end
    end

    assign ev.status = status_q;
    assign ev.role_q = role_q;
endmodule
`default_nettype wire

// [design/vrir_top.sv]
// vrir_top: byte register bank for VCONN detect status, soft reset, the
// fixed reserved registers and the extended event interrupt mask.
// assumes the I2C slave engine and CC detection logic share clk, so no
// synchroniser sits on their signals; one register is addressed per access.
`timescale 1ns/1ps
`default_nettype none
module vrir_top
    import vrir_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    // byte register port from the I2C slave engine
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [7:0]                reg_wdata,
    output logic      [7:0]                reg_rdata,
    output logic                           reg_rvalid,
    // CC detection logic
    input  wire vrir_pkg::vrir_port_e      port_mode,
    input  wire logic                      resolved_source,
    input  wire logic                      source_attached,
    input  wire logic                      ra_on_cc1,
    input  wire logic                      ra_on_cc2,
    input  wire logic [VRIR_EVT_WIDTH-1:0] ext_event,
    input  wire logic [2:0]                attach_status,
    // outputs to the rest of the unit
    output logic                           vconn_en_cc1,
    output logic                           vconn_en_cc2,
    output logic                           digital_reset,
    output logic [2:0]                     attach_role,
    output logic                           irq
);
    import vrir_pkg::*;

    // read contents of the reserved registers, writes never reach them
    function automatic logic [7:0] rsvd_value(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            VRIR_OFS_RSVD_A: v = VRIR_RST_RSVD_A;
            VRIR_OFS_RSVD_B: v = VRIR_RST_RSVD_B;
            VRIR_OFS_RSVD_C: v = VRIR_RST_RSVD_C;
            VRIR_OFS_RSVD_D: v = VRIR_RST_RSVD_D;
            VRIR_OFS_RSVD_E: v = VRIR_RST_RSVD_E;
            VRIR_OFS_RSVD_F: v = VRIR_RST_RSVD_F;
            VRIR_OFS_RSVD_G: v = VRIR_RST_RSVD_G;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic is_rsvd(input logic [7:0] addr);
        return (addr >= VRIR_OFS_RSVD_A) && (addr <= VRIR_OFS_RSVD_G);
    endfunction

    logic                      soft_rst_q;
    logic                      rst;
    logic [7:0]                unlock_q;
    logic [VRIR_EVT_WIDTH-1:0] mask_q;
    logic [1:0]                vconn_det_q;
    logic [1:0]                vconn_det_d;
    logic                      source_role;
    logic                      vconn_en_cc1_q;
    logic                      vconn_en_cc2_q;
    logic [7:0]                rdata_q;
    logic                      rvalid_q;
    logic                      irq_q;
    logic                      wr_reset;
    logic                      wr_mask;
    logic                      wr_unlock;
    logic                      unlocked;
    logic [7:0]                rd_mux;

    vrir_evt_if evt_bus ();

    // the soft reset pulse also clears this bank in the same cycle, so the
    // mask and unlock key come back to their power-up values with the core
    assign rst = reset | soft_rst_q;

    assign wr_reset  = reg_wr && (reg_addr == VRIR_OFS_RESET);
    assign wr_mask   = reg_wr && (reg_addr == VRIR_OFS_MASK);
    assign wr_unlock = reg_wr && (reg_addr == VRIR_OFS_UNLOCK);

    // self-clearing: the register always reads back zero; a write that lands
    // in the pulse cycle is lost with every other access, so the pulse is one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_reset && reg_wdata[VRIR_SOFT_RESET_BIT] && !soft_rst_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            unlock_q <= VRIR_RST_UNLOCK;
        end else if (wr_unlock) begin
            unlock_q <= reg_wdata;
        end
    end

    assign unlocked = (unlock_q == VRIR_UNLOCK_KEY);

    // bits 7:5 have no storage and read as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= VRIR_RST_MASK;
        end else if (wr_mask) begin
            mask_q <= reg_wdata[VRIR_EVT_WIDTH-1:0];
        end
    end

    // Ra on both pins is an audio accessory, which takes no VCONN
    always_comb begin
        vconn_det_d = VRIR_VCONN_STANDBY;
        if (ra_on_cc1 && !ra_on_cc2) begin
            vconn_det_d = VRIR_VCONN_CC1;
        end else if (ra_on_cc2 && !ra_on_cc1) begin
            vconn_det_d = VRIR_VCONN_CC2;
        end
    end

    // detection tracks the comparators whatever the port mode
    always_ff @(posedge clk) begin
        if (rst) begin
            vconn_det_q <= VRIR_VCONN_STANDBY;
        end else begin
            vconn_det_q <= vconn_det_d;
        end
    end

    always_comb begin
        case (port_mode)
            VRIR_PORT_DFP: source_role = 1'b1;
            VRIR_PORT_DRP: source_role = resolved_source;
            VRIR_PORT_UFP: source_role = 1'b0;
            default:       source_role = 1'b0;
        endcase
    end

    // enable does not wait for the unlock key; only the readback is gated
    always_ff @(posedge clk) begin
        if (rst) begin
            vconn_en_cc1_q <= 1'b0;
            vconn_en_cc2_q <= 1'b0;
        end else begin
            vconn_en_cc1_q <= source_role && source_attached
                              && (vconn_det_q == VRIR_VCONN_CC1);
            vconn_en_cc2_q <= source_role && source_attached
                              && (vconn_det_q == VRIR_VCONN_CC2);
        end
    end

    // each access names its own offset; the address never advances here
    always_comb begin
        rd_mux = 8'h00;
        if (is_rsvd(reg_addr)) begin
            rd_mux = rsvd_value(reg_addr);
        end else begin
            case (reg_addr)
                VRIR_OFS_VCONN:  rd_mux = {6'h00, unlocked ? vconn_det_q
                                                           : VRIR_VCONN_STANDBY};
                VRIR_OFS_RESET:  rd_mux = 8'h00;
                VRIR_OFS_MASK:   rd_mux = {3'h0, mask_q};
                VRIR_OFS_STATUS: rd_mux = {3'h0, evt_bus.status};
                VRIR_OFS_UNLOCK: rd_mux = unlock_q;
                default:         rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
        end
    end

    assign evt_bus.evt     = ext_event;
    assign evt_bus.role_in = attach_status;
    assign evt_bus.rd_clr  = reg_rd && (reg_addr == VRIR_OFS_STATUS);

    vrir_event_status u_status (
        .clk (clk),
        .rst (rst),
        .ev  (evt_bus.keeper)
    );

    // each mask bit gates only its own event
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (evt_bus.status[VRIR_EVT_COMP]   && !mask_q[VRIR_EVT_COMP])
                  || (evt_bus.status[VRIR_EVT_ROLE]   && !mask_q[VRIR_EVT_ROLE])
                  || (evt_bus.status[VRIR_EVT_ORIENT] && !mask_q[VRIR_EVT_ORIENT])
                  || (evt_bus.status[VRIR_EVT_DEBUG]  && !mask_q[VRIR_EVT_DEBUG])
                  || (evt_bus.status[VRIR_EVT_AUDIO]  && !mask_q[VRIR_EVT_AUDIO]);
        end
    end

    assign reg_rdata     = rdata_q;
    assign reg_rvalid    = rvalid_q;
    assign vconn_en_cc1  = vconn_en_cc1_q;
    assign vconn_en_cc2  = vconn_en_cc2_q;
    assign digital_reset = soft_rst_q;
    assign attach_role   = evt_bus.role_q;
    assign irq           = irq_q;
endmodule
`default_nettype wire

// [verif/vrir_top_sva.sv]
// vrir_top_sva: port-level checks of the register bank, bound to vrir_top.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module vrir_top_sva
    import vrir_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_wdata,
    input wire logic [7:0]           reg_rdata,
    input wire logic                 reg_rvalid,
    input wire vrir_pkg::vrir_port_e port_mode,
    input wire logic                 source_attached,
    input wire logic                 ra_on_cc1,
    input wire logic                 ra_on_cc2,
    input wire logic [4:0]           ext_event,
    input wire logic                 vconn_en_cc1,
    input wire logic                 digital_reset,
    input wire logic                 irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // accesses in the soft reset cycle are dropped, so they are left out
    logic rd_go;
    assign rd_go = reg_rd && !digital_reset;

    rd_answer_a: assert property (rd_go |=> reg_rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("rvalid without read");
    vconn_rsvd_a: assert property (rd_go && reg_addr == 8'h0A |=> reg_rdata[7:2] == 6'h00)
        else $error("vconn upper bits set");
    mask_rsvd_a: assert property (rd_go && reg_addr == 8'h18 |=> reg_rdata[7:5] == 3'h0)
        else $error("mask upper bits set");
    fixed_c_a: assert property (rd_go && reg_addr == 8'h13 |=> reg_rdata == 8'hA1)
        else $error("fixed register changed");
    fixed_a_a: assert property (rd_go && reg_addr == 8'h11 |=> reg_rdata == 8'h0C)
        else $error("power-up register changed");
    soft_pulse_a: assert property (reg_wr && !digital_reset && reg_addr == 8'h10
        && reg_wdata[0] |=> digital_reset ##1 !digital_reset)
        else $error("soft reset pulse wrong");
    soft_clear_a: assert property (digital_reset |=> !irq && !reg_rvalid)
        else $error("bank not cleared");
    vconn_src_a: assert property (vconn_en_cc1 |-> $past(source_attached)
        && $past(port_mode) != VRIR_PORT_UFP && $past(ra_on_cc1, 2) && !$past(ra_on_cc2, 2))
        else $error("vconn enable without cause");
    cover property (rd_go && reg_addr == 8'h18);
    cover property (ext_event[3]);
    cover property (vconn_en_cc1);
endmodule
bind vrir_top vrir_top_sva i_sva (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .port_mode, .source_attached, .ra_on_cc1, .ra_on_cc2,
    .ext_event, .vconn_en_cc1, .digital_reset, .irq);
`default_nettype wire

// [verif/vrir_host_model.sv]
// vrir_host_model: byte register host standing in for the I2C engine.
// assumes calls start 1 ns after a rising edge; each returns likewise.
`timescale 1ns/1ps
`default_nettype none
module vrir_host_model (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h5A;
        reg_wdata = 8'hA5;
    end
    // one byte per access; idle lines show the inverse so stale data never passes
    // a leading idle edge keeps a release and the next request apart in time
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = !(a inside {[8'h13:8'h17]})
            && !(a == 8'h11 && d != 8'h0C);
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        v = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [verif/vrir_top_tb.sv]
// vrir_top_tb: self-checking bench for the register bank and its host.
// assumes 20 MHz clk; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module vrir_top_tb;
    import vrir_pkg::*;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, w;
    logic       reg_wr, reg_rd, reg_rvalid, v, vconn_en_cc1, vconn_en_cc2, digital_reset, irq;
    logic       resolved_source = 1'b0, source_attached = 1'b0;
    logic       ra_on_cc1 = 1'b0, ra_on_cc2 = 1'b0;
    vrir_port_e port_mode = VRIR_PORT_UFP;
    logic [4:0] ext_event = 5'h00;
    logic [2:0] attach_status = 3'h0, attach_role;
    int         failures = 0, check_count = 0, seed = 32'hb9c315d9, i;
    logic [7:0] offs [13] = '{8'h0A, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                              8'h17, 8'h18, 8'h19, 8'h43, 8'h20};

    always #25 clk = ~clk;
    vrir_host_model i_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    vrir_top i_dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .port_mode, .resolved_source, .source_attached, .ra_on_cc1,
        .ra_on_cc2, .ext_event, .attach_status, .vconn_en_cc1, .vconn_en_cc2,
        .digital_reset, .attach_role, .irq);

    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            8'h11: return 8'h0C;
            8'h13: return 8'hA1;
            8'h14: return 8'h1F;
            8'h15: return 8'hC9;
            8'h16: return 8'h51;
            8'h17: return 8'h50;
            8'h18: return 8'h1F;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [1:0] det(input logic c1, input logic c2);
        return (c1 && !c2) ? 2'h1 : ((c2 && !c1) ? 2'h2 : 2'h0);
    endfunction
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d, v);
        chk("rvalid", {7'h00, v}, 8'h01);
        chk("rdata", d, e);
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        tally_and_finish;
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        foreach (offs[k]) rchk(offs[k], rst_val(offs[k]));
        i_host.wr(8'h11, 8'h0C);
        rchk(8'h11, 8'h0C);
        for (i = 0; i < 20; i++) begin
            w = 8'($random(seed));
            i_host.wr(8'h18, w);
            rchk(8'h18, w & 8'h1F);
        end
        ra_on_cc1 = 1'b1;
        repeat (3) step();
        rchk(8'h0A, 8'h00);
        i_host.wr(8'h43, 8'hE0);
        for (i = 0; i < 24; i++) begin
            w = 8'($random(seed));
            port_mode = vrir_port_e'(i % 4);
            {source_attached, resolved_source, ra_on_cc2, ra_on_cc1} = w[3:0];
            repeat (2) step();
            chk("vconn_en", {6'h00, vconn_en_cc2, vconn_en_cc1},
                (source_attached && (port_mode == VRIR_PORT_DFP || (port_mode ==
                VRIR_PORT_DRP && resolved_source))) ? {6'h00, det(w[0], w[1])} : 8'h00);
            rchk(8'h0A, {6'h00, det(w[0], w[1])});
        end
        i_host.wr(8'h43, 8'h00);
        rchk(8'h0A, 8'h00);
        i_host.wr(8'h18, 8'h1F);
        for (i = 0; i < 5; i++) begin
            w = 8'($random(seed));
            attach_status = w[2:0];
            ext_event = 5'h01 << i;
            step();
            ext_event = 5'h00;
            step();
            chk("irq_masked", {7'h00, irq}, 8'h00);
            if (i == 3) chk("role", {5'h00, attach_role}, {5'h00, w[2:0]});
            i_host.wr(8'h18, 8'h1F & ~(8'h01 << i));
            step();
            chk("irq", {7'h00, irq}, 8'h01);
            rchk(8'h19, 8'h01 << i);
            step();
            chk("irq_clear", {7'h00, irq}, 8'h00);
            i_host.wr(8'h18, 8'h1F);
        end
        i_host.wr(8'h18, 8'h00);
        i_host.wr(8'h10, 8'hFE);
        chk("no_reset", {7'h00, digital_reset}, 8'h00);
        i_host.wr(8'h10, 8'h01);
        chk("soft_reset", {7'h00, digital_reset}, 8'h01);
        step();
        rchk(8'h18, 8'h1F);
        chk("role_reset", {5'h00, attach_role}, 8'h00);
        tally_and_finish;
    end
endmodule
`default_nettype wire
